// ===== shared/pdm_pkg.sv
package pdm_pkg;

    localparam logic [7:0] PDM_ADR_CONTROL = 8'h00;
    localparam logic [7:0] PDM_ADR_CLOCK   = 8'h04;
    localparam logic [7:0] PDM_ADR_STATUS  = 8'h08;

    localparam logic [7:0] PDM_RST_CONTROL = 8'h00;
    localparam logic [7:0] PDM_RST_CLOCK   = 8'h00;

    // Writable bits; everything else reads back as zero
    localparam logic [7:0] PDM_MASK_CONTROL = 8'hf0;
    localparam logic [7:0] PDM_MASK_CLOCK   = 8'hbc;

    localparam int PDM_BIT_STANDBY_SEL  = 7;
    localparam int PDM_POS_WAIT_SEL     = 4;
    localparam int PDM_BIT_SUBSLEEP_SEL = 7;
    localparam int PDM_BIT_DIRECT_FLAG  = 5;
    localparam int PDM_POS_DIV_SEL      = 2;

    localparam logic [17:0] PDM_WAIT_1K  = 18'h00400;
    localparam logic [17:0] PDM_WAIT_128 = 18'h00080;
    localparam logic [17:0] PDM_WAIT_16  = 18'h00010;
    localparam logic [17:0] PDM_WAIT_8K  = 18'h02000;
    localparam logic [17:0] PDM_WAIT_16K = 18'h04000;
    localparam logic [17:0] PDM_WAIT_32K = 18'h08000;
    localparam logic [17:0] PDM_WAIT_64K = 18'h10000;
    localparam logic [17:0] PDM_WAIT_128K = 18'h20000;

    localparam logic [5:0] PDM_DIV_BASE = 6'h08;

    typedef enum logic [2:0] {
        PDM_ACTIVE    = 3'h0,
        PDM_STANDBY   = 3'h1,
        PDM_WAKE_WAIT = 3'h3,
        PDM_SLEEP     = 3'h2,
        PDM_SUBSLEEP  = 3'h6
    } pdm_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pdm_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pdm_wb_rsp_t;

    typedef struct packed {
        logic cpu_halt;
        logic periph_halt;
        logic osc_stop;
        logic prescaler_clear;
        logic sys_tick;
    } pdm_power_t;

endpackage

// ===== design/pdm_control.sv
`timescale 1ns/10ps
module pdm_control #(
    parameter logic [17:0] WAIT_8K   = pdm_pkg::PDM_WAIT_8K,
    parameter logic [17:0] WAIT_16K  = pdm_pkg::PDM_WAIT_16K,
    parameter logic [17:0] WAIT_32K  = pdm_pkg::PDM_WAIT_32K,
    parameter logic [17:0] WAIT_64K  = pdm_pkg::PDM_WAIT_64K,
    parameter logic [17:0] WAIT_128K = pdm_pkg::PDM_WAIT_128K
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire pdm_pkg::pdm_wb_req_t wb_req_i,
    output pdm_pkg::pdm_wb_rsp_t      wb_rsp_o,
    input  wire logic                 sleep_exec_i,
    input  wire logic                 wake_irq_i,
    output pdm_pkg::pdm_power_t       power_o,
    output logic [2:0]                mode_o,
    output logic [2:0]                div_active_o
);

    typedef struct packed {
        pdm_pkg::pdm_state_t  st;
        logic [7:0]           ctl;
        logic [7:0]           clk;
        logic [2:0]           div_act;
        logic [17:0]          wait_cnt;
        logic [5:0]           pre_cnt;
        pdm_pkg::pdm_power_t  pwr;
        pdm_pkg::pdm_wb_rsp_t rsp;
    } pdm_regs_t;

    pdm_regs_t s;
    pdm_regs_t next_s;

    function automatic logic [17:0] wait_target(input logic [2:0] code);
        case (code)
            3'h0:    wait_target = WAIT_8K;
            3'h1:    wait_target = WAIT_16K;
            3'h2:    wait_target = WAIT_32K;
            3'h3:    wait_target = WAIT_64K;
            3'h4:    wait_target = WAIT_128K;
            3'h5:    wait_target = pdm_pkg::PDM_WAIT_1K;
            3'h6:    wait_target = pdm_pkg::PDM_WAIT_128;
            default: wait_target = pdm_pkg::PDM_WAIT_16;
        endcase
    endfunction

    // Terminal count of the prescaler; zero means every cycle
    function automatic logic [5:0] div_limit(input logic [2:0] code);
        if (!code[2]) begin
            div_limit = 6'h00;
        end else begin
            div_limit = 6'((pdm_pkg::PDM_DIV_BASE << code[1:0]) - 6'h01);
        end
    endfunction

    function automatic pdm_pkg::pdm_state_t sleep_target(input logic [7:0] ctl,
                                                         input logic [7:0] clk);
        if (clk[pdm_pkg::PDM_BIT_DIRECT_FLAG] && !clk[pdm_pkg::PDM_BIT_SUBSLEEP_SEL]) begin
            sleep_target = pdm_pkg::PDM_ACTIVE;
        end else if (ctl[pdm_pkg::PDM_BIT_STANDBY_SEL]) begin
            sleep_target = pdm_pkg::PDM_STANDBY;
        end else if (clk[pdm_pkg::PDM_BIT_SUBSLEEP_SEL]) begin
            sleep_target = pdm_pkg::PDM_SUBSLEEP;
        end else begin
            sleep_target = pdm_pkg::PDM_SLEEP;
        end
    endfunction

    logic       bus_req;
    logic       bus_wr;
    logic [2:0] wait_code;
    logic       osc_halted;

    assign bus_req   = wb_req_i.cyc && wb_req_i.stb && !s.rsp.ack;
    assign bus_wr    = bus_req && wb_req_i.we && wb_req_i.sel[0];
    assign wait_code = s.ctl[pdm_pkg::PDM_POS_WAIT_SEL +: 3];

    always_comb begin
        next_s = s;
        next_s.rsp.ack = bus_req;
        next_s.rsp.dat = 32'h0000_0000;
        if (bus_req && !wb_req_i.we) begin
            case (wb_req_i.adr)
                pdm_pkg::PDM_ADR_CONTROL: next_s.rsp.dat = {24'h00_0000, s.ctl};
                pdm_pkg::PDM_ADR_CLOCK:   next_s.rsp.dat = {24'h00_0000, s.clk};
                pdm_pkg::PDM_ADR_STATUS:  next_s.rsp.dat = {26'h000_0000, s.div_act, s.st};
                default:                  next_s.rsp.dat = 32'h0000_0000;
            endcase
        end
        if (bus_wr) begin
            case (wb_req_i.adr)
                pdm_pkg::PDM_ADR_CONTROL:
                    next_s.ctl = wb_req_i.dat[7:0] & pdm_pkg::PDM_MASK_CONTROL;
                pdm_pkg::PDM_ADR_CLOCK:
                    next_s.clk = wb_req_i.dat[7:0] & pdm_pkg::PDM_MASK_CLOCK;
                default: ;
            endcase
        end

        case (s.st)
            pdm_pkg::PDM_ACTIVE: begin
                if (sleep_exec_i) begin
                    next_s.st      = sleep_target(s.ctl, s.clk);
                    // Divider switches only here, never on the register write
                    next_s.div_act = s.clk[pdm_pkg::PDM_POS_DIV_SEL +: 3];
                end
            end
            pdm_pkg::PDM_SLEEP, pdm_pkg::PDM_SUBSLEEP: begin
                if (wake_irq_i) begin
                    next_s.st = pdm_pkg::PDM_ACTIVE;
                end
            end
            pdm_pkg::PDM_STANDBY: begin
                if (wake_irq_i) begin
                    next_s.st       = pdm_pkg::PDM_WAKE_WAIT;
                    next_s.wait_cnt = 18'h00000;
                end
            end
            pdm_pkg::PDM_WAKE_WAIT: begin
                if (s.wait_cnt == 18'(wait_target(wait_code) - 18'h00001)) begin
                    next_s.st = pdm_pkg::PDM_ACTIVE;
                end else begin
                    next_s.wait_cnt = 18'(s.wait_cnt + 18'h00001);
                end
            end
            default: next_s.st = pdm_pkg::PDM_ACTIVE;
        endcase

        osc_halted = next_s.st == pdm_pkg::PDM_STANDBY || next_s.st == pdm_pkg::PDM_SUBSLEEP;
        if (osc_halted) begin
            next_s.pre_cnt      = 6'h00;
            next_s.pwr.sys_tick = 1'b0;
        end else if (s.pre_cnt >= div_limit(next_s.div_act)) begin
            next_s.pre_cnt      = 6'h00;
            next_s.pwr.sys_tick = 1'b1;
        end else begin
            next_s.pre_cnt      = 6'(s.pre_cnt + 6'h01);
            next_s.pwr.sys_tick = 1'b0;
        end
        next_s.pwr.osc_stop        = osc_halted;
        next_s.pwr.prescaler_clear = osc_halted;
        next_s.pwr.cpu_halt        = next_s.st != pdm_pkg::PDM_ACTIVE;
        // Peripherals keep running in sleep; the wake wait holds them too
        next_s.pwr.periph_halt     = next_s.st != pdm_pkg::PDM_ACTIVE
                                     && next_s.st != pdm_pkg::PDM_SLEEP;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s         <= '0;
            s.ctl     <= pdm_pkg::PDM_RST_CONTROL;
            s.clk     <= pdm_pkg::PDM_RST_CLOCK;
            s.st      <= pdm_pkg::PDM_ACTIVE;
            s.pwr.sys_tick <= 1'b0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign wb_rsp_o     = s.rsp;
    assign power_o      = s.pwr;
    assign mode_o       = s.st;
    assign div_active_o = s.div_act;

    standby_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.st == pdm_pkg::PDM_ACTIVE && sleep_exec_i && s.ctl[7] && !s.clk[5]
        |=> s.st == pdm_pkg::PDM_STANDBY)
        else $error("standby not entered");

    sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.st == pdm_pkg::PDM_ACTIVE && sleep_exec_i && !s.ctl[7] && !s.clk[7]
        && !s.clk[5] |=> s.st == pdm_pkg::PDM_SLEEP && power_o.cpu_halt && !power_o.periph_halt)
        else $error("sleep not entered");

    direct_trans_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.st == pdm_pkg::PDM_ACTIVE && sleep_exec_i && s.clk[5] && !s.clk[7]
        |=> s.st == pdm_pkg::PDM_ACTIVE && div_active_o == $past(s.clk[4:2]))
        else $error("direct transition wrong");

    subsleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.st == pdm_pkg::PDM_ACTIVE && sleep_exec_i && !s.ctl[7] && s.clk[7]
        |=> s.st == pdm_pkg::PDM_SUBSLEEP)
        else $error("subsleep not entered");

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.ctl & ~pdm_pkg::PDM_MASK_CONTROL) == 8'h00
        && (s.clk & ~pdm_pkg::PDM_MASK_CLOCK) == 8'h00)
        else $error("reserved bit set");

    div_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ce_i && s.st == pdm_pkg::PDM_ACTIVE && sleep_exec_i) |=> $stable(div_active_o))
        else $error("divider changed without sleep");

    wake_short_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s.st == pdm_pkg::PDM_STANDBY && wake_irq_i && ce_i && s.ctl[6:4] == 3'h7
        |=> (s.st == pdm_pkg::PDM_WAKE_WAIT && power_o.cpu_halt) [*8])
        else $error("wake wait released early");

    wake_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.st == pdm_pkg::PDM_WAKE_WAIT && s.wait_cnt == 18'(wait_target(wait_code) - 1)
        |=> s.st == pdm_pkg::PDM_ACTIVE && !power_o.cpu_halt && !power_o.periph_halt)
        else $error("wake wait not released");

    osc_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.st == pdm_pkg::PDM_STANDBY || s.st == pdm_pkg::PDM_SUBSLEEP)
        |-> power_o.osc_stop && s.pre_cnt == 6'h00 && !power_o.sys_tick)
        else $error("prescaler not halted");

    irq_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wake_irq_i && (s.st == pdm_pkg::PDM_SLEEP || s.st == pdm_pkg::PDM_SUBSLEEP)
        |=> s.st == pdm_pkg::PDM_ACTIVE)
        else $error("interrupt did not wake");

    div8_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && power_o.sys_tick && div_active_o == 3'h4 && s.st == pdm_pkg::PDM_ACTIVE
        ##1 ce_i [*7] |-> !power_o.sys_tick)
        else $error("divide by 8 tick spacing wrong");

endmodule

// ===== testbench/pdm_cpu_model.sv
`timescale 1ns/10ps
module pdm_cpu_model (
    input  wire logic clk_i,
    output logic      sleep_exec_o,
    output logic      wake_irq_o
);
    initial begin
        sleep_exec_o = 1'b0;
        wake_irq_o   = 1'b0;
    end
    // One-cycle pulse, as the core issues the instruction once
    task automatic do_sleep;
        @(posedge clk_i);
        sleep_exec_o <= 1'b1;
        @(posedge clk_i);
        sleep_exec_o <= 1'b0;
    endtask
    task automatic do_wake;
        @(posedge clk_i);
        wake_irq_o <= 1'b1;
        @(posedge clk_i);
        wake_irq_o <= 1'b0;
    endtask
endmodule

// ===== testbench/power_down_mode_control_tb_top.sv
`timescale 1ns/10ps
module power_down_mode_control_tb_top;
    logic                 clk_i  = 1'b0;
    logic                 rst_i  = 1'b1;
    logic                 ce_i   = 1'b1;
    pdm_pkg::pdm_wb_req_t wb_req = '0;
    pdm_pkg::pdm_wb_rsp_t wb_rsp;
    pdm_pkg::pdm_power_t  pwr;
    logic [2:0]           mode;
    logic [2:0]           div;
    logic                 sleep_exec;
    logic                 wake_irq;
    logic [31:0]          rd;
    int                   n_fail    = 0;
    int                   cmp_count = 0;
    int                   cycles    = 0;
    int                   n;
    logic [7:0]           ctl_tab [6] = '{8'h00, 8'h00, 8'hf0, 8'h00, 8'h00, 8'h80};
    logic [7:0]           clk_tab [6] = '{8'h00, 8'h80, 8'h00, 8'h20, 8'ha0, 8'h20};
    logic [2:0]           mode_tab[6] = '{3'h2, 3'h6, 3'h1, 3'h0, 3'h6, 3'h0};
    logic [2:0]           wcode   [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    int                   wexp    [7] = '{20, 24, 28, 32, 36, 1024, 128};

    always #2.5 clk_i = ~clk_i;

    pdm_control #(.WAIT_8K(18'h00014), .WAIT_16K(18'h00018), .WAIT_32K(18'h0001c),
                  .WAIT_64K(18'h00020), .WAIT_128K(18'h00024)) uut (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .wb_req_i     (wb_req),
        .wb_rsp_o     (wb_rsp),
        .sleep_exec_i (sleep_exec),
        .wake_irq_i   (wake_irq),
        .power_o      (pwr),
        .mode_o       (mode),
        .div_active_o (div)
    );
    pdm_cpu_model cpu (.clk_i(clk_i), .sleep_exec_o(sleep_exec), .wake_irq_o(wake_irq));

    task automatic end_of_test;
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    // Classic cycle: hold until ack is seen at an edge, then release
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        @(posedge clk_i);
        wb_req.cyc <= 1'b1;
        wb_req.stb <= 1'b1;
        wb_req.we  <= we;
        wb_req.adr <= adr;
        wb_req.sel <= 4'hf;
        wb_req.dat <= {24'h0, dat};
        // No local limit; the cycle ceiling ends a hung wait as a failure
        do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        wb_req.we  <= 1'b0;
    endtask
    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask
    task automatic tick_gap(output int g);
        g = 0;
        do @(posedge clk_i); while (pwr.sys_tick !== 1'b1 && cycles < 29000);
        do begin
            @(posedge clk_i);
            g++;
        end while (pwr.sys_tick !== 1'b1 && g < 200);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, pdm_pkg::PDM_ADR_CONTROL, 8'h00); chk(rd, 32'h0);
        wb(1'b0, pdm_pkg::PDM_ADR_CLOCK, 8'h00); chk(rd, 32'h0);
        wb(1'b1, pdm_pkg::PDM_ADR_CONTROL, 8'hff);
        wb(1'b0, pdm_pkg::PDM_ADR_CONTROL, 8'h00); chk(rd, 32'hf0);
        wb(1'b1, pdm_pkg::PDM_ADR_CLOCK, 8'hff);
        wb(1'b0, pdm_pkg::PDM_ADR_CLOCK, 8'h00); chk(rd, 32'hbc);
        wb(1'b1, 8'h0c, 8'hff);
        wb(1'b0, 8'h0c, 8'h00); chk(rd, 32'h0);
        // Every row of the mode table, then back out by interrupt from each row whose mode is not active
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, pdm_pkg::PDM_ADR_CONTROL, ctl_tab[i]);
            wb(1'b1, pdm_pkg::PDM_ADR_CLOCK, clk_tab[i]);
            cpu.do_sleep();
            settle();
            chk(32'(mode), 32'(mode_tab[i]));
            chk(32'(pwr.osc_stop), 32'(mode_tab[i][0] | mode_tab[i][2]));
            chk(32'(pwr.prescaler_clear), 32'(mode_tab[i][0] | mode_tab[i][2]));
            chk(32'(pwr.cpu_halt), 32'(mode_tab[i] != 3'h0));
            chk(32'(pwr.periph_halt), 32'(mode_tab[i][0] | mode_tab[i][2]));
            if (mode_tab[i] != 3'h0) begin
                cpu.do_wake();
                n = 0;
                #1;
                while (mode === 3'h3 && n < 300) begin
                    n++;
                    settle();
                end
                chk(n, (mode_tab[i] == 3'h1) ? 16 : 0);
                settle();
                chk(32'(mode), 32'h0);
                chk(32'(pwr.cpu_halt), 32'h0);
                chk(32'(pwr.periph_halt), 32'h0);
            end
        end
        // Wake-wait codes 0 to 6; codes 0 to 4 use the shortened count parameters, 5 and 6 the 1024 and 128 counts
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, pdm_pkg::PDM_ADR_CONTROL, {1'b1, wcode[i], 4'h0});
            wb(1'b1, pdm_pkg::PDM_ADR_CLOCK, 8'h00);
            cpu.do_sleep();
            settle();
            cpu.do_wake();
            n = 0;
            #1;
            chk(32'({pwr.cpu_halt, pwr.periph_halt}), 32'h3);
            while (mode === 3'h3 && n < 1100) begin
                n++;
                settle();
            end
            chk(n, wexp[i]);
        end
        // Divider loads only when the sleep instruction runs
        for (int c = 3; c < 8; c++) begin
            wb(1'b1, pdm_pkg::PDM_ADR_CLOCK, 8'h20 | 8'(c << 2));
            settle();
            chk(32'(div), (c == 3) ? 32'h0 : 32'(c - 1));
            cpu.do_sleep();
            settle();
            chk(32'(div), 32'(c));
            wb(1'b0, pdm_pkg::PDM_ADR_STATUS, 8'h00); chk(rd[5:3], 32'(c));
            tick_gap(n);
            chk(n, (c < 4) ? 1 : (8 << (c - 4)));
        end
        // Enable low freezes all state, so this sleep pulse is lost
        wb(1'b1, pdm_pkg::PDM_ADR_CONTROL, 8'h80);
        wb(1'b1, pdm_pkg::PDM_ADR_CLOCK, 8'h00);
        ce_i <= 1'b0;
        cpu.do_sleep();
        settle();
        chk(32'(mode), 32'h0);
        chk(32'(div), 32'h7);
        @(posedge clk_i);
        ce_i <= 1'b1;
        cpu.do_sleep();
        settle();
        chk(32'(mode), 32'h1);
        chk(32'(div), 32'h0);
        end_of_test();
    end
endmodule
